// >>> design/config_reg_file.sv
/*
  Configuration register store reached by the two-wire control port.
  Assumes a single clock; the owner gives one write strobe per byte.
*/
`include "two_wire_defs.svh"

module config_reg_file (
  input  wire logic   clk_i,    // System clock
  input  wire logic   reset_i,  // Synchronous reset, active high
  input  wire logic   ce_i,     // Clock enable
  reg_port_if.store   port      // Access path
);
  import two_wire_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Storage
  logic [7:0] mem_reg [0:`TW_REG_LIMIT-1];  // Register contents

  // Decode shared by reads and writes
  function automatic logic implemented(input logic [7:0] addr);
    implemented = addr < `TW_REG_LIMIT;
  endfunction

  wire wr_ok = port.wr_en & implemented(port.wr_addr);  // Holes drop the write
  wire rd_ok = implemented(port.rd_addr);               // Holes read as zero

  // Read answer
  assign port.rd_data = rd_ok ? mem_reg[port.rd_addr[6:0]] : 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // Write port, whole array cleared on reset
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < `TW_REG_LIMIT; i++) begin
        mem_reg[i] <= `TW_REG_RESET;
      end
    end else if (ce_i && wr_ok) begin
      mem_reg[port.wr_addr[6:0]] <= port.wr_data;
    end
  end
endmodule // config_reg_file

// >>> design/reg_port_if.sv
/*
  Access path between the protocol engines and the configuration register store.
  Assumes one owner drives requests and the store answers reads combinationally.
*/
interface reg_port_if;
  logic       wr_en;    // One-cycle write strobe
  logic [7:0] wr_addr;  // Write sub-address
  logic [7:0] wr_data;  // Write value
  logic [7:0] rd_addr;  // Read sub-address
  logic [7:0] rd_data;  // Read value

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr,
                 input rd_data);
  modport store (input wr_en, input wr_addr, input wr_data, input rd_addr,
                 output rd_data);
endinterface // reg_port_if

// >>> design/two_wire_control_port.sv
/*
  Two-wire control port: slave access to the configuration registers and a
  start-up master that loads them from an external storage slave.
  Assumes open-drain pins resolved outside and a pull-up on each line.
*/
`include "two_wire_defs.svh"

module two_wire_control_port (
  input  wire logic CLK_I,                       // System clock, 200 MHz
  input  wire logic RESET_I,                     // Synchronous reset, active high
  input  wire logic CE_I,                        // Clock enable, freezes state
  input  wire logic BOOT_LOAD_I,                 // Strap: run the loader after reset
  input  wire logic SERIAL_CLOCK_LINE_I,         // Clock line level
  output logic      SERIAL_CLOCK_LINE_O,         // Clock line drive value, always low
  output logic      SERIAL_CLOCK_LINE_OE_O,      // Clock line pulled low
  input  wire logic SERIAL_DATA_LINE_I,          // Data line level
  output logic      SERIAL_DATA_LINE_O,          // Data line drive value, always low
  output logic      SERIAL_DATA_LINE_OE_O,       // Data line pulled low
  output logic      LOAD_BUSY_O,                 // Loader owns the bus
  output logic      LOAD_FAIL_O,                 // Storage did not acknowledge
  output logic      REG_WR_O,                    // Write strobe, one cycle, also for holes
  output logic [7:0] REG_ADDR_O,                 // Sub-address written
  output logic [7:0] REG_DATA_O                  // Value written
);
  import two_wire_pkg::*;

  localparam logic [6:0] QCYC = 7'(`TW_QUARTER_CYC);  // Quarter bit in cycles

  reg_port_if rp ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; first stage feeds only the second
  logic scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic sda_meta_reg, sda_sync_reg, sda_prev_reg;
  logic boot_meta_reg, boot_sync_reg;

  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      {scl_meta_reg, scl_sync_reg, scl_prev_reg} <= 3'h7;
      {sda_meta_reg, sda_sync_reg, sda_prev_reg} <= 3'h7;
      {boot_meta_reg, boot_sync_reg}             <= 2'h0;
    end else if (CE_I) begin
      {scl_meta_reg, scl_sync_reg, scl_prev_reg} <= {SERIAL_CLOCK_LINE_I, scl_meta_reg, scl_sync_reg};
      {sda_meta_reg, sda_sync_reg, sda_prev_reg} <= {SERIAL_DATA_LINE_I, sda_meta_reg, sda_sync_reg};
      {boot_meta_reg, boot_sync_reg}             <= {BOOT_LOAD_I, boot_meta_reg};
    end
  end

  // Line events, data edge while clock high is a condition
  wire scl_rise = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall = ~scl_sync_reg & scl_prev_reg;
  wire start_c  = scl_sync_reg & scl_prev_reg & sda_prev_reg & ~sda_sync_reg;
  wire stop_c   = scl_sync_reg & scl_prev_reg & ~sda_prev_reg & sda_sync_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Slave engine state
  slave_state_t s_state_reg;     // Protocol position
  logic [3:0]   bitcnt_reg;      // Bits seen in this byte
  logic         in_ack_reg;      // In acknowledge slot
  logic [7:0]   s_shift_reg;     // Byte shifter
  logic [7:0]   sub_reg;         // Stored sub-address
  logic         s_drive_reg;     // Pull data low
  logic         rw_reg;          // Direction bit of address byte
  logic         m_ack_reg;       // Master acknowledged last read byte
  load_state_t  ld_state_reg;    // Loader phase

  wire slave_on  = ld_state_reg == L_DONE;  // Slave listens once loading ends
  wire s_active  = s_state_reg != S_IDLE && s_state_reg != S_IGNORE;
  wire byte_end  = scl_fall & ~in_ack_reg & (bitcnt_reg == 4'd8) & s_active;
  wire ack_end   = scl_fall & in_ack_reg & s_active;
  wire id_match  = s_shift_reg == `TW_SLAVE_WR_ID || s_shift_reg == `TW_SLAVE_RD_ID;
  wire slave_wr  = slave_on & byte_end & (s_state_reg == S_WDATA);  // Third byte is data
  // Next read byte comes from the following sub-address while in the ack slot
  wire [7:0] s_rd_addr = (s_state_reg == S_RDATA && in_ack_reg) ? 8'(sub_reg + 8'h01) : sub_reg;

  // Slave protocol; bits act on clock edges, start and stop on data edges, so data moves while low
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      s_state_reg <= S_IDLE;
      bitcnt_reg  <= 4'h0;
      in_ack_reg  <= 1'b0;
      s_shift_reg <= 8'h00;
      sub_reg     <= 8'h00;
      s_drive_reg <= 1'b0;
      rw_reg      <= 1'b0;
      m_ack_reg   <= 1'b0;
    end else if (CE_I && slave_on) begin
      if (start_c) begin                       // Any start resynchronises
        s_state_reg <= S_ADDR;
        bitcnt_reg  <= 4'h0;
        in_ack_reg  <= 1'b0;
        s_drive_reg <= 1'b0;
      end else if (stop_c) begin
        s_state_reg <= S_IDLE;
        in_ack_reg  <= 1'b0;
        s_drive_reg <= 1'b0;
      end else if (scl_rise && s_active && !in_ack_reg) begin
        bitcnt_reg <= 4'(bitcnt_reg + 4'h1);
        if (s_state_reg != S_RDATA) begin
          s_shift_reg <= {s_shift_reg[6:0], sda_sync_reg};  // MSB first
        end
      end else if (scl_rise && in_ack_reg && s_state_reg == S_RDATA) begin
        m_ack_reg <= ~sda_sync_reg;            // Master answers a read byte
      end else if (byte_end) begin
        in_ack_reg <= 1'b1;
        bitcnt_reg <= 4'h0;
        case (s_state_reg)
          S_ADDR: begin
            if (id_match) begin
              s_drive_reg <= 1'b1;             // Acknowledge our identifier
              rw_reg      <= s_shift_reg[0];   // Direction in the LSB
            end else begin
              s_state_reg <= S_IGNORE;         // Stay released
            end
          end
          S_SUB: begin
            sub_reg     <= s_shift_reg;        // Second byte is sub-address
            s_drive_reg <= 1'b1;
          end
          S_WDATA: s_drive_reg <= 1'b1;        // Acknowledge even for holes
          S_RDATA: s_drive_reg <= 1'b0;        // Release for master's answer
          default: s_drive_reg <= 1'b0;
        endcase
      end else if (ack_end) begin
        in_ack_reg  <= 1'b0;
        s_drive_reg <= 1'b0;
        case (s_state_reg)
          S_ADDR: begin
            if (rw_reg) begin                  // Read uses held sub-address
              s_state_reg <= S_RDATA;
              s_shift_reg <= rp.rd_data;
              s_drive_reg <= ~rp.rd_data[7];   // Open drain: low or released
            end else begin
              s_state_reg <= S_SUB;
            end
          end
          S_SUB:   s_state_reg <= S_WDATA;
          S_WDATA: sub_reg <= 8'(sub_reg + 8'h01);   // Step after each data byte
          S_RDATA: begin
            if (m_ack_reg) begin
              sub_reg     <= 8'(sub_reg + 8'h01);
              s_shift_reg <= rp.rd_data;
              s_drive_reg <= ~rp.rd_data[7];
            end else begin
              s_state_reg <= S_IGNORE;         // Not acknowledged: read over
            end
          end
          default: s_state_reg <= S_IGNORE;
        endcase
      end else if (scl_fall && s_state_reg == S_RDATA && !in_ack_reg) begin
        s_shift_reg <= {s_shift_reg[6:0], 1'b0};     // Next bit after falling edge
        s_drive_reg <= ~s_shift_reg[6];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Loader: per pair, set pointer, stop, then read two bytes
  logic [1:0] arm_reg;       // Strap settling count
  logic [3:0] step_reg;      // Operation within a pair
  logic [1:0] q_reg;         // Quarter within a bit
  logic [6:0] qcnt_reg;      // Cycles within a quarter
  logic [3:0] idx_reg;       // Bit within a byte, 8 is the ack slot
  logic [7:0] ld_shift_reg;  // Loader byte shifter
  logic [6:0] pair_reg;      // Pair index
  logic [7:0] ld_sub_reg;    // Fetched sub-address
  logic [7:0] ld_val_reg;    // Fetched value
  logic       abort_reg;     // Storage failed to acknowledge

  // Operation of each step
  wire bus_op_t op = (step_reg == 4'd0 || step_reg == 4'd4) ? OP_START :
                     (step_reg == 4'd3 || step_reg == 4'd8) ? OP_STOP :
                     (step_reg == 4'd6 || step_reg == 4'd7) ? OP_RX : OP_TX;
  wire quarter_end = qcnt_reg == QCYC - 7'd1;
  wire bit_last    = op == OP_START || op == OP_STOP || idx_reg == 4'd8;
  wire terminator  = ld_sub_reg == `TW_STOP_MARK && ld_val_reg == `TW_STOP_MARK;
  wire ld_wr       = ld_state_reg == L_APPLY && !abort_reg && !terminator;

  // Byte sent by a transmit step
  function automatic logic [7:0] tx_byte(input logic [3:0] step, input logic [6:0] pair);
    case (step)
      4'd1:    tx_byte = `TW_STORE_WR_ID;
      4'd2:    tx_byte = {pair, 1'b0};          // Even location holds sub-address
      default: tx_byte = `TW_STORE_RD_ID;
    endcase
  endfunction

  // Line pulls per operation and quarter, {clock low, data low}
  function automatic logic [1:0] bus_drive(input bus_op_t o, input logic [1:0] q,
                                           input logic [3:0] i, input logic b,
                                           input logic nack);
    case (o)
      OP_START: bus_drive = {q == 2'd3, q >= 2'd2};          // Data falls, clock high
      OP_STOP:  bus_drive = {q == 2'd0, q <= 2'd1};          // Data rises, clock high
      OP_TX:    bus_drive = {q == 2'd0 || q == 2'd3, i < 4'd8 && !b};
      default:  bus_drive = {q == 2'd0 || q == 2'd3, i == 4'd8 && !nack};
    endcase
  endfunction

  wire [1:0] ld_pull = bus_drive(op, q_reg, idx_reg, ld_shift_reg[7], step_reg == 4'd7);

  // Quarter timer
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      qcnt_reg <= 7'h00;
    end else if (CE_I) begin
      qcnt_reg <= (ld_state_reg == L_RUN && !quarter_end) ? 7'(qcnt_reg + 7'h01) : 7'h00;
    end
  end

  // Loader sequencer
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      ld_state_reg <= L_ARM;
      arm_reg      <= 2'h0;
      step_reg     <= 4'h0;
      q_reg        <= 2'h0;
      idx_reg      <= 4'h0;
      ld_shift_reg <= 8'h00;
      pair_reg     <= `TW_FIRST_PAIR;
      ld_sub_reg   <= 8'h00;
      ld_val_reg   <= 8'h00;
      abort_reg    <= 1'b0;
    end else if (CE_I) begin
      case (ld_state_reg)
        L_ARM: begin                           // Strap read after it settles
          arm_reg <= 2'(arm_reg + 2'h1);
          if (arm_reg == `TW_ARM_CYC) begin
            ld_state_reg <= boot_sync_reg ? L_RUN : L_DONE;
          end
        end
        L_RUN: begin
          if (quarter_end) begin
            q_reg <= 2'(q_reg + 2'h1);
            if (q_reg == 2'd2) begin           // Sample while clock is high
              if (op == OP_RX && idx_reg < 4'd8) begin
                ld_shift_reg <= {ld_shift_reg[6:0], sda_sync_reg};
              end
              if (op == OP_TX && idx_reg == 4'd8 && sda_sync_reg) begin
                abort_reg <= 1'b1;
              end
            end else if (q_reg == 2'd3) begin
              if (op == OP_TX && idx_reg < 4'd8) begin
                ld_shift_reg <= {ld_shift_reg[6:0], 1'b0};
              end
              if (!bit_last) begin
                idx_reg <= 4'(idx_reg + 4'h1);
              end else begin
                idx_reg <= 4'h0;
                if (step_reg == 4'd6) ld_sub_reg <= ld_shift_reg;
                if (step_reg == 4'd7) ld_val_reg <= ld_shift_reg;   // Odd location
                if (step_reg == 4'd8) begin
                  ld_state_reg <= L_APPLY;
                  step_reg     <= 4'h0;
                end else if (op == OP_TX && abort_reg) begin
                  step_reg <= 4'd8;            // Give up: stop the bus
                end else begin
                  step_reg     <= 4'(step_reg + 4'h1);
                  ld_shift_reg <= tx_byte(4'(step_reg + 4'h1), pair_reg);
                end
              end
            end
          end
        end
        L_APPLY: begin
          if (abort_reg || terminator || pair_reg == `TW_LAST_PAIR) begin
            ld_state_reg <= L_DONE;            // Terminator ends loading
          end else begin
            pair_reg     <= 7'(pair_reg + 7'h01);  // Next pair in order
            ld_state_reg <= L_RUN;
          end
        end
        default: ld_state_reg <= L_DONE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register store access, loader has the port until it is done
  assign rp.wr_en   = CE_I & (ld_wr | slave_wr);
  assign rp.wr_addr = slave_on ? sub_reg : ld_sub_reg;
  assign rp.wr_data = slave_on ? s_shift_reg : ld_val_reg;
  assign rp.rd_addr = s_rd_addr;

  config_reg_file u_regs (
    .clk_i   (CLK_I),
    .reset_i (RESET_I),
    .ce_i    (CE_I),
    .port    (rp)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registered outputs; lines are only ever pulled low
  always_ff @(posedge CLK_I) begin
    if (RESET_I) begin
      SERIAL_CLOCK_LINE_O    <= 1'b0;
      SERIAL_CLOCK_LINE_OE_O <= 1'b0;
      SERIAL_DATA_LINE_O     <= 1'b0;
      SERIAL_DATA_LINE_OE_O  <= 1'b0;
      LOAD_BUSY_O            <= 1'b1;
      LOAD_FAIL_O            <= 1'b0;
      REG_WR_O               <= 1'b0;
      REG_ADDR_O             <= 8'h00;
      REG_DATA_O             <= 8'h00;
    end else if (CE_I) begin
      SERIAL_CLOCK_LINE_OE_O <= ld_state_reg == L_RUN && ld_pull[1];
      SERIAL_DATA_LINE_OE_O  <= ld_state_reg == L_RUN ? ld_pull[0] : (slave_on & s_drive_reg);
      LOAD_BUSY_O            <= ld_state_reg != L_DONE;
      LOAD_FAIL_O            <= abort_reg;
      REG_WR_O               <= rp.wr_en;
      REG_ADDR_O             <= rp.wr_addr;
      REG_DATA_O             <= rp.wr_data;
    end
  end
endmodule // two_wire_control_port

// >>> design/two_wire_defs.svh
/*
  Constants of the two-wire control port: identifiers, map limits and bus timing.
  Assumes inclusion by bare name from the design modules and the verification files.
*/
`ifndef TWO_WIRE_DEFS_SVH
`define TWO_WIRE_DEFS_SVH

// Slave identifier bytes, write and read form
`define TW_SLAVE_WR_ID     8'h60
`define TW_SLAVE_RD_ID     8'h61
// Identifier bytes of the external storage slave, values arbitrary
`define TW_STORE_WR_ID     8'ha0
`define TW_STORE_RD_ID     8'ha1
// Terminator value for both halves of a pair
`define TW_STOP_MARK       8'hff
// Storage location of the first pair
`define TW_FIRST_PAIR      7'h00
// Last pair index before the pointer would wrap
`define TW_LAST_PAIR       7'h7f
// Sub-addresses below this limit have a register
`define TW_REG_LIMIT       8'h80
// Register contents after reset
`define TW_REG_RESET       8'h00
// Clock rate and top serial rate
`define TW_CLK_KHZ         200000
`define TW_RATE_KBPS       400
// One quarter of a serial bit, least time so rounded up
`define TW_QUARTER_CYC     ((`TW_CLK_KHZ + 4 * `TW_RATE_KBPS - 1) / (4 * `TW_RATE_KBPS))
// Cycles granted to the strap synchroniser after reset
`define TW_ARM_CYC         2'd3

`endif

// >>> design/two_wire_pkg.sv
/*
  Types of the two-wire control port: state and bus operation encodings.
  Assumes the defs header sits beside it.
*/
package two_wire_pkg;
  // Slave side protocol position
  typedef enum logic [2:0] {
    S_IDLE   = 3'b000,
    S_ADDR   = 3'b001,
    S_SUB    = 3'b010,
    S_WDATA  = 3'b011,
    S_RDATA  = 3'b100,
    S_IGNORE = 3'b101
  } slave_state_t;

  // Self-loading master phase
  typedef enum logic [1:0] {
    L_ARM   = 2'b00,
    L_RUN   = 2'b01,
    L_APPLY = 2'b10,
    L_DONE  = 2'b11
  } load_state_t;

  // Bus operation of one loader step
  typedef enum logic [1:0] {
    OP_START = 2'b00,
    OP_STOP  = 2'b01,
    OP_TX    = 2'b10,
    OP_RX    = 2'b11
  } bus_op_t;
endpackage

// >>> verif/store_model.sv
/* Storage slave that the start-up loader reads: one pair, then the terminator.
   Assumes a wired-AND data line with pull-up; pull_o high pulls it low. */
`include "two_wire_defs.svh"

module store_model #(
  parameter logic [7:0] FIRST_SUB = 8'h00,
  parameter logic [7:0] FIRST_VAL = 8'h00
) (
  input  wire logic scl_i,   // Clock line level
  input  wire logic sda_i,   // Data line level
  output logic      pull_o   // Data line pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:3];     // Pair 0, then the terminator pair
  logic [7:0] ptr;           // Storage pointer
  logic [7:0] sh;            // Receive shifter
  logic       mack;          // Master acknowledge, 1 ends the read
  // One byte in on clock rises, MSB first
  task rx_byte();
    for (int i = 0; i < 8; i++) begin
      @(posedge scl_i);
      sh = {sh[6:0], sda_i};
    end
  endtask
  // Pull for the acknowledge shortly after the clock falls
  task ack_low();
    @(negedge scl_i);
    #20 pull_o = 1'b1;
  endtask
  initial begin
    pull_o = 1'b0;
    ptr = 8'h00;
    mem = '{FIRST_SUB, FIRST_VAL, `TW_STOP_MARK, `TW_STOP_MARK};
    forever begin
      @(negedge sda_i iff scl_i === 1'b1); // Start
      rx_byte();
      if (sh == `TW_STORE_WR_ID) begin
        ack_low();
        @(negedge scl_i);
        #20 pull_o = 1'b0;
        rx_byte();
        ptr = sh;
        ack_low();
        @(negedge scl_i);
        #20 pull_o = 1'b0;
      end else if (sh == `TW_STORE_RD_ID) begin
        ack_low();
        mack = 1'b0;
        // Other identifiers are left alone until the next start
        while (mack == 1'b0) begin
          for (int i = 7; i >= 0; i--) begin
            @(negedge scl_i);
            #20 pull_o = ~mem[ptr[1:0]][i];
          end
          @(negedge scl_i);
          #20 pull_o = 1'b0;
          @(posedge scl_i);
          mack = sda_i;
          ptr = ptr + 8'h01;
        end
      end
    end
  end
endmodule // store_model

// >>> verif/two_wire_checker.sv
/* Concurrent checks on the two-wire control port top module ports.
   Assumes CE_I high and a bench serial clock far slower than CLK_I. */
`include "two_wire_defs.svh"

module two_wire_checker (
  input wire logic       CLK_I,
  input wire logic       RESET_I,
  input wire logic       SERIAL_CLOCK_LINE_I,
  input wire logic       SERIAL_CLOCK_LINE_O,
  input wire logic       SERIAL_CLOCK_LINE_OE_O,
  input wire logic       SERIAL_DATA_LINE_O,
  input wire logic       SERIAL_DATA_LINE_OE_O,
  input wire logic       LOAD_BUSY_O,
  input wire logic       LOAD_FAIL_O,
  input wire logic       REG_WR_O,
  input wire logic [7:0] REG_ADDR_O,
  input wire logic [7:0] REG_DATA_O
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (RESET_I);
  ////////////////////////////////////////////////////////////////////////////////
  // Slave pull starts, then must stand at least a few cycles
  sequence slave_pull;
    $rose(SERIAL_DATA_LINE_OE_O) && !LOAD_BUSY_O;
  endsequence
  sequence pull_held;
    SERIAL_DATA_LINE_OE_O [*8];
  endsequence
  // Two writes of one frame land on consecutive sub-addresses
  property sub_step;
    logic [7:0] a;
    (REG_WR_O && !LOAD_BUSY_O, a = REG_ADDR_O) ##[1:400] REG_WR_O
      |-> REG_ADDR_O == 8'(a + 8'h01);
  endproperty
  ////////////////////////////////////////////////////////////////////////////////
  a_reset_outputs: assert property (disable iff (1'b0) RESET_I |=>
    !SERIAL_DATA_LINE_OE_O && !SERIAL_CLOCK_LINE_OE_O && LOAD_BUSY_O && !LOAD_FAIL_O && !REG_WR_O)
    else $error("outputs wrong after reset");
  a_data_open_drain: assert property (SERIAL_DATA_LINE_O == 1'b0)
    else $error("data line driven high");
  a_clock_open_drain: assert property (SERIAL_CLOCK_LINE_O == 1'b0)
    else $error("clock line driven high");
  a_slave_no_clock: assert property (!LOAD_BUSY_O |-> !SERIAL_CLOCK_LINE_OE_O)
    else $error("slave pulls clock line");
  a_slave_data_stable: assert property (
    !LOAD_BUSY_O && $changed(SERIAL_DATA_LINE_OE_O) |-> !SERIAL_CLOCK_LINE_I)
    else $error("slave data changed while clock high");
  a_ack_pull_held: assert property (slave_pull |-> pull_held)
    else $error("slave pull too short");
  a_sub_auto_step: assert property (sub_step)
    else $error("sub-address did not step by one");
  a_load_stays_done: assert property (!LOAD_BUSY_O |=> !LOAD_BUSY_O)
    else $error("loader restarted");
  a_no_mark_write: assert property (REG_WR_O && LOAD_BUSY_O |->
    !(REG_ADDR_O == `TW_STOP_MARK && REG_DATA_O == `TW_STOP_MARK))
    else $error("terminator pair written");
endmodule // two_wire_checker

bind two_wire_control_port two_wire_checker two_wire_checker_inst (.CLK_I(CLK_I),
  .RESET_I(RESET_I), .SERIAL_CLOCK_LINE_I(SERIAL_CLOCK_LINE_I),
  .SERIAL_CLOCK_LINE_O(SERIAL_CLOCK_LINE_O), .SERIAL_CLOCK_LINE_OE_O(SERIAL_CLOCK_LINE_OE_O),
  .SERIAL_DATA_LINE_O(SERIAL_DATA_LINE_O), .SERIAL_DATA_LINE_OE_O(SERIAL_DATA_LINE_OE_O),
  .LOAD_BUSY_O(LOAD_BUSY_O), .LOAD_FAIL_O(LOAD_FAIL_O), .REG_WR_O(REG_WR_O),
  .REG_ADDR_O(REG_ADDR_O), .REG_DATA_O(REG_DATA_O));

// >>> verif/two_wire_control_port_bench.sv
/* Bench of the two-wire control port: boot load, slave writes and reads, foreign id.
   Assumes pull-ups on both lines, modelled as a wired-AND of all pulls. */
`include "two_wire_defs.svh"

module two_wire_control_port_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] BOOT_SUB = 8'h12; // Pair held in storage
  localparam logic [7:0] BOOT_VAL = 8'h34;
  logic        clk = 1'b0, rst = 1'b1, boot = 1'b1;
  logic        m_scl = 1'b1, m_sda = 1'b1; // Bench master, 1 releases
  logic        scl_oe, sda_oe, scl_o, sda_o, busy, fail, wr, pull, ackb;
  logic [7:0]  waddr, wdata, got, s, id;
  logic [7:0]  dat [0:2];
  logic [7:0]  shadow [0:127];             // Expected register contents
  logic [15:0] wq [$];                     // Register writes seen
  int          fail_count = 0, comparisons = 0, n;
  wire scl_line = m_scl & ~scl_oe;
  wire sda_line = m_sda & ~sda_oe & ~pull;
  initial forever #2.5 clk = ~clk;
  two_wire_control_port two_wire_control_port_inst (.CLK_I(clk), .RESET_I(rst), .CE_I(1'b1),
    .BOOT_LOAD_I(boot), .SERIAL_CLOCK_LINE_I(scl_line), .SERIAL_CLOCK_LINE_O(scl_o),
    .SERIAL_CLOCK_LINE_OE_O(scl_oe), .SERIAL_DATA_LINE_I(sda_line), .SERIAL_DATA_LINE_O(sda_o),
    .SERIAL_DATA_LINE_OE_O(sda_oe), .LOAD_BUSY_O(busy), .LOAD_FAIL_O(fail), .REG_WR_O(wr),
    .REG_ADDR_O(waddr), .REG_DATA_O(wdata));
  store_model #(.FIRST_SUB(BOOT_SUB), .FIRST_VAL(BOOT_VAL)) store_model_inst (
    .scl_i(scl_line), .sda_i(sda_line), .pull_o(pull));
  always @(negedge clk) if (wr === 1'b1) wq.push_back({waddr, wdata});
  ////////////////////////////////////////////////////////////////////////////////
  task check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", nm, e, g);
    end
  endtask
  task check_bit(input string nm, input logic e, input logic g);
    check_byte(nm, {7'h00, e}, {7'h00, g});
  endtask
  task print_verdict();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  function logic [7:0] exp_rd(input logic [7:0] a);
    exp_rd = (a < `TW_REG_LIMIT) ? shadow[a[6:0]] : 8'h00;
  endfunction
  ////////////////////////////////////////////////////////////////////////////////
  // Bench master: 160 ns bit, four quarters, data bits change only while clock low
  task q();
    repeat (8) @(negedge clk);
  endtask
  task bit_c(input logic b, output logic r);
    m_sda = b;
    q();
    m_scl = 1'b1;
    q();
    r = sda_line;
    q();
    m_scl = 1'b0;
    q();
  endtask
  task byte_c(input logic [7:0] d, input logic a);
    for (int i = 7; i >= 0; i--) bit_c(d[i], got[i]);
    bit_c(a, ackb);
  endtask
  task start_c();
    q();
    m_sda = 1'b0;
    q();
    m_scl = 1'b0;
  endtask
  task stop_c();
    m_sda = 1'b0;
    q();
    m_scl = 1'b1;
    q();
    m_sda = 1'b1;
    repeat (8) q();
  endtask
  task wr_frame(input logic [7:0] sub, input int cnt);
    start_c();
    byte_c(`TW_SLAVE_WR_ID, 1'b1);
    check_bit("id ack", 1'b0, ackb);
    byte_c(sub, 1'b1);
    check_bit("sub ack", 1'b0, ackb);
    for (int k = 0; k < cnt; k++) begin
      byte_c(dat[k], 1'b1);
      check_bit("data ack", 1'b0, ackb);
      if (8'(sub + k) < `TW_REG_LIMIT) shadow[7'(sub + k)] = dat[k];
    end
    stop_c();
  endtask
  task rd_frame(input logic [7:0] sub, input int cnt);
    start_c();
    byte_c(`TW_SLAVE_RD_ID, 1'b1);
    check_bit("read id ack", 1'b0, ackb);
    for (int k = 0; k < cnt; k++) begin
      byte_c(8'hff, k == cnt - 1);
      check_byte("read data", exp_rd(8'(sub + k)), got);
    end
    stop_c();
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    for (int k = 0; k < 128; k++) shadow[k] = `TW_REG_RESET;
    void'($urandom(80952));
    repeat (4) @(negedge clk);
    rst = 1'b0;
    for (int k = 0; k < 70000 && busy !== 1'b0; k++) @(negedge clk);
    check_bit("load busy", 1'b0, busy);
    if (busy !== 1'b0) print_verdict();
    check_byte("boot writes", 8'h01, 8'(wq.size()));
    check_byte("boot sub", BOOT_SUB, wq[0][15:8]);
    check_byte("boot value", BOOT_VAL, wq[0][7:0]);
    check_bit("load fail", 1'b0, fail);
    shadow[BOOT_SUB[6:0]] = BOOT_VAL;
    wr_frame(BOOT_SUB, 0);
    rd_frame(BOOT_SUB, 1);
    $display("test boot load done");
    for (int t = 0; t < 4; t++) begin
      s = (t == 0) ? 8'h7e : 8'($urandom_range(0, 127));
      n = (t == 0) ? 3 : int'($urandom_range(1, 3));
      for (int k = 0; k < 3; k++) dat[k] = 8'($urandom);
      wq.delete();
      wr_frame(s, n);
      check_byte("write count", 8'(n), 8'(wq.size()));
      for (int k = 0; k < n; k++) begin
        check_byte("write sub", 8'(s + k), wq[k][15:8]);
        check_byte("write value", dat[k], wq[k][7:0]);
      end
      wr_frame(s, 0); // New sub-address before reading
      rd_frame(s, n);
      $display("test write and read %0d done", t);
    end
    id = {1'b0, 7'($urandom)};
    if (id[7:1] == 7'h30) id = 8'h42;
    wq.delete();
    start_c();
    byte_c(id, 1'b1);
    check_bit("foreign ack", 1'b1, ackb);
    byte_c(8'h00, 1'b1);
    check_bit("foreign released", 1'b1, ackb);
    stop_c();
    check_byte("foreign writes", 8'h00, 8'(wq.size()));
    $display("test foreign id done");
    rst = 1'b1; // Mid-run reset, strap low
    boot = 1'b0;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    repeat (8) @(negedge clk);
    check_bit("strap low busy", 1'b0, busy);
    $display("test strap low done");
    print_verdict();
  end
endmodule // two_wire_control_port_bench
